// ===== rtl/power_mgmt_control_regs.v
`timescale 1ns/1ns
`include "power_mgmt_consts.vh"

// Notes on behaviour
// - Restore flag with bit 7 raises interrupt
// - Sag flag with bit 5 raises interrupt
// - Converter flag with bit 3 raises interrupt
// - Battery level flag with bit 2 raises interrupt
// - Switchover flag with bit 1 raises interrupt
// - Comparator flag with bit 0 raises interrupt
// - Four scratch bytes read, write, retained
// - Scratch cleared only when both supplies lost
// - Bit 6 stops metering in full power
// - Bit 4 on battery enters deep sleep
// - Divider field sets core clock, resets 010
// - Power control writable only right after key
// - Rail fed by main or battery supply
// - External control input can force battery
// - Flags set regardless of enable bits
// - Flags latched until software writes zero
// - Master enable gates the shared interrupt
module power_mgmt_control_regs (
    input  wire       core_clk,
    input  wire       rst_n,                 // Power-on reset, async, low
    input  wire       retention_rst_n,       // Low only when main and battery both lost
    input  wire [7:0] sfr_addr,              // Special function register address
    input  wire       sfr_wr,                // Write strobe, one cycle
    input  wire       sfr_rd,                // Read strobe, one cycle
    input  wire [7:0] sfr_wdata,             // Write data
    input  wire       sag_evt,               // Voltage sag detected, pulse
    input  wire       supervisory_conv_evt,  // Supervisory conversion event, pulse
    input  wire       battery_level_evt,     // Battery monitor event, pulse
    input  wire       supervisory_cmp_evt,   // Supervisory comparator event, pulse
    input  wire       supply_irq_master_en,  // Master enable of the shared interrupt
    input  wire       vdd_ok,                // Main supply good
    input  wire       vdcin_ok,              // Supervisory input good
    input  wire       battery_control_input, // External battery control pin
    input  wire       battery_control_en,    // External control pin enabled
    input  wire [1:0] switchover_cfg,        // Switchover detector configuration
    output reg  [7:0] sfr_rdata_q,           // Read data, valid cycle after strobe
    output reg        supply_irq_q,          // Shared interrupt request, level
    output reg        metering_shutdown_q,   // Modulators and metering off
    output reg        deep_sleep_mode_q,     // Core shut down, deepest saving mode
    output reg  [2:0] core_clock_divider_q,  // Core clock exponent
    output reg        internal_supply_rail_q,// 1 = rail on main, 0 = on battery
    output reg        full_power_mode_q,     // Running from main supply
    output reg        battery_run_mode_q     // Running from battery
);

    // Register state
    reg  [7:0] irq_enable_q;     // Event interrupt enables
    reg  [7:0] event_flags_q;    // Latched event flags
    reg  [7:0] event_flags_d;
    reg  [7:0] power_control_q;  // Stored power control bits
    reg        key_unlocked_q;   // Key written by the previous write
    reg  [7:0] scratch_q [0:3];  // Retained scratch bytes
    reg  [7:0] read_mux;         // Combinational read data
    reg  [7:0] new_events;       // Events seen this cycle
    reg        irq_d;

    wire       rail_on_battery;
    wire       switchover_evt;
    wire       restore_evt;
    wire       scratch_hit;
    wire [1:0] scratch_idx;
    wire       pctl_write;
    integer    i;

    // Address match, used by every register except the scratch bytes
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Scratch window covers four consecutive addresses
    function in_scratch;
        input [7:0] addr;
        begin
            in_scratch = (addr >= `PM_ADDR_SCRATCH_A) && (addr <= `PM_ADDR_SCRATCH_D);
        end
    endfunction

    assign scratch_hit = in_scratch(sfr_addr);
    assign scratch_idx = sfr_addr[1:0] - 2'h3;
    // Only the write right after the key is honoured
    assign pctl_write  = sfr_wr && hit(sfr_addr, `PM_ADDR_POWER_CONTROL) && key_unlocked_q;

    // Supply source selection and change events
    supply_switch_select u_switch (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .vdd_ok                (vdd_ok),
        .vdcin_ok              (vdcin_ok),
        .battery_control_input (battery_control_input),
        .battery_control_en    (battery_control_en),
        .switchover_cfg        (switchover_cfg),
        .rail_on_battery_q     (rail_on_battery),
        .switchover_evt_q      (switchover_evt),
        .restore_evt_q         (restore_evt)
    );

    // Gather this cycle's events into flag positions
    always @* begin
        new_events = 8'h00;
        new_events[`PM_BIT_RESTORE]          = restore_evt;
        new_events[`PM_BIT_SAG]              = sag_evt;
        new_events[`PM_BIT_SUPERVISORY_CONV] = supervisory_conv_evt;
        new_events[`PM_BIT_BATTERY_LEVEL]    = battery_level_evt;
        new_events[`PM_BIT_SWITCHOVER]       = switchover_evt;
        new_events[`PM_BIT_SUPERVISORY_CMP]  = supervisory_cmp_evt;
    end

    // Flag next state: write zero clears, a new event wins over the clear
    always @* begin
        event_flags_d = event_flags_q;
        if (sfr_wr && hit(sfr_addr, `PM_ADDR_EVENT_FLAGS)) begin
            event_flags_d = event_flags_q & sfr_wdata;
        end
        // Setting ignores the enables entirely
        event_flags_d = (event_flags_d | new_events) & `PM_EVENT_FLAGS_MASK;
    end

    // Interrupt request from enabled flags
    always @* begin
        irq_d = 1'b0;
        if (irq_enable_q[`PM_BIT_RESTORE] && event_flags_q[`PM_BIT_RESTORE]) begin
            irq_d = 1'b1;
        end
        if (irq_enable_q[`PM_BIT_SAG] && event_flags_q[`PM_BIT_SAG]) begin
            irq_d = 1'b1;
        end
        if (irq_enable_q[`PM_BIT_SUPERVISORY_CONV] && event_flags_q[`PM_BIT_SUPERVISORY_CONV]) begin
            irq_d = 1'b1;
        end
        if (irq_enable_q[`PM_BIT_BATTERY_LEVEL] && event_flags_q[`PM_BIT_BATTERY_LEVEL]) begin
            irq_d = 1'b1;
        end
        if (irq_enable_q[`PM_BIT_SWITCHOVER] && event_flags_q[`PM_BIT_SWITCHOVER]) begin
            irq_d = 1'b1;
        end
        if (irq_enable_q[`PM_BIT_SUPERVISORY_CMP] && event_flags_q[`PM_BIT_SUPERVISORY_CMP]) begin
            irq_d = 1'b1;
        end
        // Stays high while any enabled flag stays set and the master enable is high
        irq_d = irq_d && supply_irq_master_en;
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        read_mux = 8'h00;
        if (hit(sfr_addr, `PM_ADDR_POWER_CONTROL)) begin
            read_mux = power_control_q | `PM_PCTL_FIXED_BITS;
        end else if (hit(sfr_addr, `PM_ADDR_IRQ_ENABLE)) begin
            read_mux = irq_enable_q;
        end else if (hit(sfr_addr, `PM_ADDR_EVENT_FLAGS)) begin
            read_mux = event_flags_q;
        end else if (scratch_hit) begin
            read_mux = scratch_q[scratch_idx];
        end
    end

    // Enables, flags, key and interrupt, all on power-on reset
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_q   <= `PM_IRQ_ENABLE_RESET;
            event_flags_q  <= `PM_EVENT_FLAGS_RESET;
            key_unlocked_q <= 1'b0;
            supply_irq_q   <= 1'b0;
            sfr_rdata_q    <= 8'h00;
        end else begin
            event_flags_q <= event_flags_d;
            supply_irq_q  <= irq_d;
            // Bit 6 reads zero; bit 4 stored as written, software keeps it low
            if (sfr_wr && hit(sfr_addr, `PM_ADDR_IRQ_ENABLE)) begin
                irq_enable_q <= sfr_wdata & `PM_IRQ_ENABLE_MASK;
            end
            // Any write consumes the unlock; only the key write arms it
            if (sfr_wr) begin
                key_unlocked_q <= hit(sfr_addr, `PM_ADDR_WRITE_KEY) &&
                                  (sfr_wdata == `PM_WRITE_KEY_VALUE);
            end
            if (sfr_rd) begin
                sfr_rdata_q <= read_mux;
            end
        end
    end

    // Power control register, key protected
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_control_q <= `PM_PCTL_RESET;
        end else if (pctl_write) begin
            // Reserved bits are not stored; bit 7 is forced on read
            power_control_q <= sfr_wdata & `PM_PCTL_WRITE_MASK;
        end
    end

    // Scratch bytes live on the retention reset only, so mode changes and
    // the power-on reset leave them alone
    always @(posedge core_clk or negedge retention_rst_n) begin
        if (!retention_rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                scratch_q[i] <= `PM_SCRATCH_RESET;
            end
        end else if (sfr_wr && scratch_hit) begin
            scratch_q[scratch_idx] <= sfr_wdata;
        end
    end

    // Mode and control outputs, registered
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            metering_shutdown_q    <= 1'b0;
            deep_sleep_mode_q      <= 1'b0;
            core_clock_divider_q   <= `PM_DIV_RESET;
            internal_supply_rail_q <= 1'b1;
            full_power_mode_q      <= 1'b1;
            battery_run_mode_q     <= 1'b0;
        end else begin
            internal_supply_rail_q <= !rail_on_battery;
            full_power_mode_q      <= !rail_on_battery;
            battery_run_mode_q     <= rail_on_battery;
            // Metering can only be switched off while on the main supply
            metering_shutdown_q <= power_control_q[`PM_PCTL_BIT_METERING_SHUTDOWN] && !rail_on_battery;
            // Core shutdown is only meaningful when running from battery
            deep_sleep_mode_q <= power_control_q[`PM_PCTL_BIT_CORE_OFF] && rail_on_battery;
            // Core clock is 4.096 MHz shifted right by this field
            core_clock_divider_q <= power_control_q[`PM_PCTL_DIV_MSB:`PM_PCTL_DIV_LSB];
        end
    end

endmodule

// ===== rtl/power_mgmt_consts.vh
`ifndef POWER_MGMT_CONSTS_VH
`define POWER_MGMT_CONSTS_VH

// Special function register addresses
`define PM_ADDR_POWER_CONTROL   8'hC5
`define PM_ADDR_WRITE_KEY       8'hC1
`define PM_ADDR_IRQ_ENABLE      8'hEC
`define PM_ADDR_EVENT_FLAGS     8'hF8
`define PM_ADDR_SCRATCH_A       8'hFB
`define PM_ADDR_SCRATCH_B       8'hFC
`define PM_ADDR_SCRATCH_C       8'hFD
`define PM_ADDR_SCRATCH_D       8'hFE

// Unlock key for the power control register
`define PM_WRITE_KEY_VALUE      8'hA7

// Event bit positions, shared by enable and flag registers
`define PM_BIT_RESTORE          7
`define PM_BIT_RESERVED6        6
`define PM_BIT_SAG              5
`define PM_BIT_RESERVED4        4
`define PM_BIT_SUPERVISORY_CONV 3
`define PM_BIT_BATTERY_LEVEL    2
`define PM_BIT_SWITCHOVER       1
`define PM_BIT_SUPERVISORY_CMP  0

// Implemented bits and reset values of the enable and flag registers
`define PM_IRQ_ENABLE_MASK      8'hBF
`define PM_IRQ_ENABLE_RESET     8'h00
`define PM_EVENT_FLAGS_RESET    8'h00
`define PM_EVENT_FLAGS_MASK     8'hBF

// Power control layout
`define PM_PCTL_BIT_FIXED_ONE   7
`define PM_PCTL_BIT_METERING_SHUTDOWN 6
`define PM_PCTL_BIT_CORE_OFF    4
`define PM_PCTL_DIV_MSB         2
`define PM_PCTL_DIV_LSB         0
`define PM_PCTL_WRITE_MASK      8'h57
`define PM_PCTL_FIXED_BITS      8'h80
`define PM_PCTL_RESET           8'h82
`define PM_DIV_RESET            3'h2

// Scratch reset value
`define PM_SCRATCH_RESET        8'h00

// Switchover configuration codes
`define PM_SWCFG_VDD_ONLY       2'h0
`define PM_SWCFG_VDD_AND_DCIN   2'h1

`endif

// ===== rtl/supply_switch_select.v
`timescale 1ns/1ns
`include "power_mgmt_consts.vh"

// Decides which supply feeds the internal rail and reports the changes
module supply_switch_select (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       vdd_ok,                // Main supply above its threshold
    input  wire       vdcin_ok,              // Supervisory input above its threshold
    input  wire       battery_control_input, // External switchover request, low = battery
    input  wire       battery_control_en,    // External control input honoured
    input  wire [1:0] switchover_cfg,        // Which level detectors may switch
    output reg        rail_on_battery_q,     // Internal supply rail source
    output reg        switchover_evt_q,      // One-cycle pulse, rail moved to battery
    output reg        restore_evt_q          // One-cycle pulse, rail back on main
);

    reg  pin_prev_q;  // Last sampled external control level
    reg  pin_hold_q;  // Switchover held by the external input
    wire pin_fall;
    wire level_low;
    wire want_battery;

    // Level detectors enabled by configuration; code 1X disables level switching
    assign level_low = !switchover_cfg[1] &&
                       (!vdd_ok || ((switchover_cfg == `PM_SWCFG_VDD_AND_DCIN) && !vdcin_ok));
    assign pin_fall = battery_control_en && pin_prev_q && !battery_control_input;
    // Either main or battery feeds the rail, never both
    assign want_battery = level_low || pin_fall || pin_hold_q;

    // Falling edge of the control input latches a switchover until it rises or battery_control_en drops
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_q <= 1'b1;
            pin_hold_q <= 1'b0;
        end else begin
            pin_prev_q <= battery_control_input;
            if (pin_fall) begin
                pin_hold_q <= 1'b1;
            end else if (!battery_control_en || battery_control_input) begin
                pin_hold_q <= 1'b0;
            end
        end
    end

    // Rail source and its change events
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_on_battery_q <= 1'b0;
            switchover_evt_q  <= 1'b0;
            restore_evt_q     <= 1'b0;
        end else begin
            rail_on_battery_q <= want_battery;
            switchover_evt_q  <= want_battery && !rail_on_battery_q;
            restore_evt_q     <= !want_battery && rail_on_battery_q;
        end
    end

endmodule

// ===== verification/power_mgmt_chk.sv
`timescale 1ns/1ns
// Watches unlock, divider, mode gating and interrupt timing at the ports
module power_mgmt_chk (
    input wire       core_clk,
    input wire       rst_n,
    input wire [7:0] sfr_addr,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire       sag_evt,
    input wire       supervisory_conv_evt,
    input wire       battery_level_evt,
    input wire       supervisory_cmp_evt,
    input wire       supply_irq_master_en,
    input wire       supply_irq_q,
    input wire       metering_shutdown_q,
    input wire       deep_sleep_mode_q,
    input wire [2:0] core_clock_divider_q,
    input wire       internal_supply_rail_q,
    input wire       full_power_mode_q,
    input wire       battery_run_mode_q
);
    reg        key_q; // Previous write was the unlock key
    reg  [7:0] en_q;  // Shadow of the enable register
    wire [3:0] hit;   // Event pulses whose enable is set

    // Shadows follow bus writes; any write consumes the unlock
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_q <= 1'b0;
            en_q  <= 8'h00;
        end else if (sfr_wr) begin
            key_q <= (sfr_addr == 8'hC1) && (sfr_wdata == 8'hA7);
            if (sfr_addr == 8'hEC) begin
                en_q <= sfr_wdata;
            end
        end
    end

    assign hit = {sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt}
               & {en_q[5], en_q[3], en_q[2], en_q[0]};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_div_reset; $rose(rst_n) |-> core_clock_divider_q == 3'h2; endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not at reset code");
    // Register stage then output stage: the divider follows two edges after the write
    property p_key_ok; key_q && sfr_wr && sfr_addr == 8'hC5 |-> ##2 core_clock_divider_q == $past(sfr_wdata[2:0], 2);
    endproperty
    a_key_ok: assert property (p_key_ok) else $error("unlocked divider write lost");
    property p_key_bad; !key_q && sfr_wr && sfr_addr == 8'hC5 |=> ##1 $stable(core_clock_divider_q); endproperty
    a_key_bad: assert property (p_key_bad) else $error("locked power control changed");
    property p_meter; metering_shutdown_q |-> full_power_mode_q || $past(full_power_mode_q); endproperty
    a_meter: assert property (p_meter) else $error("metering off outside full power");
    property p_deep; deep_sleep_mode_q |-> battery_run_mode_q || $past(battery_run_mode_q); endproperty
    a_deep: assert property (p_deep) else $error("deep sleep outside battery mode");
    property p_rail; internal_supply_rail_q == full_power_mode_q && full_power_mode_q != battery_run_mode_q; endproperty
    a_rail: assert property (p_rail) else $error("rail and mode disagree");
    property p_evt; (|hit) && supply_irq_master_en ##1 supply_irq_master_en |=> supply_irq_q; endproperty
    a_evt: assert property (p_evt) else $error("enabled event gave no request");
    property p_swap; ($fell(internal_supply_rail_q) && en_q[1] || $rose(internal_supply_rail_q) && en_q[7])
        && supply_irq_master_en |=> supply_irq_q; endproperty
    a_swap: assert property (p_swap) else $error("supply change gave no request");
    property p_master; !supply_irq_master_en |=> !supply_irq_q; endproperty
    a_master: assert property (p_master) else $error("request without master enable");
endmodule

bind power_mgmt_control_regs power_mgmt_chk power_mgmt_chk_i (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sag_evt(sag_evt), .supervisory_conv_evt(supervisory_conv_evt), .battery_level_evt(battery_level_evt),
    .supervisory_cmp_evt(supervisory_cmp_evt), .supply_irq_master_en(supply_irq_master_en),
    .supply_irq_q(supply_irq_q), .metering_shutdown_q(metering_shutdown_q), .deep_sleep_mode_q(deep_sleep_mode_q),
    .core_clock_divider_q(core_clock_divider_q), .internal_supply_rail_q(internal_supply_rail_q),
    .full_power_mode_q(full_power_mode_q), .battery_run_mode_q(battery_run_mode_q));

// ===== verification/power_mgmt_control_regs_tb.sv
`timescale 1ns/1ns
module power_mgmt_control_regs_tb;
    reg        core_clk, rst_n, retention_rst_n, sfr_wr, sfr_rd, supply_irq_master_en;  // Clock, resets, strobes
    reg        sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt;   // Event pulses
    reg        vdd_ok, vdcin_ok, battery_control_input, battery_control_en;            // Supply side levels
    reg  [1:0] switchover_cfg;                                                       // Detector selection
    reg  [7:0] sfr_addr, sfr_wdata;                                                  // Bus request
    wire [7:0] sfr_rdata_q;                                                          // Read data
    wire [2:0] core_clock_divider_q;                                                 // Divider code
    wire       supply_irq_q, metering_shutdown_q, deep_sleep_mode_q;                 // Status levels
    wire       internal_supply_rail_q, full_power_mode_q, battery_run_mode_q;        // Supply mode
    int        error_cnt = 0, n_tests = 0, cyc = 0, i, k;                           // Bookkeeping
    int        bits [4] = '{5, 3, 2, 0};                                             // Enable bit per event

    power_mgmt_control_regs power_mgmt_control_regs_i (
        .core_clk(core_clk), .rst_n(rst_n), .retention_rst_n(retention_rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sag_evt(sag_evt),
        .supervisory_conv_evt(supervisory_conv_evt), .battery_level_evt(battery_level_evt),
        .supervisory_cmp_evt(supervisory_cmp_evt), .supply_irq_master_en(supply_irq_master_en),
        .vdd_ok(vdd_ok), .vdcin_ok(vdcin_ok), .battery_control_input(battery_control_input),
        .battery_control_en(battery_control_en), .switchover_cfg(switchover_cfg), .sfr_rdata_q(sfr_rdata_q),
        .supply_irq_q(supply_irq_q), .metering_shutdown_q(metering_shutdown_q),
        .deep_sleep_mode_q(deep_sleep_mode_q), .core_clock_divider_q(core_clock_divider_q),
        .internal_supply_rail_q(internal_supply_rail_q), .full_power_mode_q(full_power_mode_q),
        .battery_run_mode_q(battery_run_mode_q));

    // 50 ns clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task summarize;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Tasks start and end 2 ns after a rising edge
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    // Strobe stays low across one edge, so back to back calls never merge
    task wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask

    // Read data is registered at the strobe edge, so it is settled on return
    task rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        chk("rdata", sfr_rdata_q, exp);
        tick(1);
    endtask

    initial begin
        {rst_n, retention_rst_n, sfr_wr, sfr_rd, supply_irq_master_en, battery_control_en} = 6'h00;
        {sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt} = 4'h0;
        {vdd_ok, vdcin_ok, battery_control_input} = 3'h7;
        switchover_cfg = 2'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        tick(20);
        {rst_n, retention_rst_n, supply_irq_master_en} = 3'h7;
        rd(8'hC5, 8'h82);
        rd(8'hEC, 8'h00);
        // Scratch bytes survive a core reset, cleared only by retention loss
        for (i = 0; i < 4; i++) wr(8'hFB + i[7:0], 8'hC3 - i[7:0]);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        for (i = 0; i < 4; i++) rd(8'hFB + i[7:0], 8'hC3 - i[7:0]);
        retention_rst_n = 1'b0;
        tick(1);
        retention_rst_n = 1'b1;
        for (i = 0; i < 4; i++) rd(8'hFB + i[7:0], 8'h00);
        // Reserved bit 6 written high reads back low; bit 4 kept low
        wr(8'hEC, 8'hEF);
        rd(8'hEC, 8'hAF);
        rd(8'h00, 8'h00);
        // Each monitor event: flag, enable, master gate, clear
        for (k = 0; k < 4; k++) begin
            wr(8'hEC, 8'h00);
            {sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt} = 4'h8 >> k;
            tick(1);
            {sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt} = 4'h0;
            rd(8'hF8, 8'h01 << bits[k]);
            chk("irq", {7'h00, supply_irq_q}, 8'h00);
            wr(8'hEC, 8'h01 << bits[k]);
            tick(1);
            chk("irq", {7'h00, supply_irq_q}, 8'h01);
            supply_irq_master_en = 1'b0;
            tick(2);
            chk("irq", {7'h00, supply_irq_q}, 8'h00);
            supply_irq_master_en = 1'b1;
            // Clear of a set flag and a fresh event in one cycle: the event wins
            sfr_addr = 8'hF8;
            sfr_wdata = 8'h00;
            sfr_wr = 1'b1;
            {sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt} = 4'h8 >> k;
            tick(1);
            sfr_wr = 1'b0;
            {sag_evt, supervisory_conv_evt, battery_level_evt, supervisory_cmp_evt} = 4'h0;
            tick(1);
            rd(8'hF8, 8'h01 << bits[k]);
            chk("irq", {7'h00, supply_irq_q}, 8'h01);
            wr(8'hF8, 8'h00);
            tick(2);
            chk("irq", {7'h00, supply_irq_q}, 8'h00);
        end
        // Power control needs the key right before it
        wr(8'hC5, 8'h43);
        rd(8'hC5, 8'h82);
        wr(8'hC1, 8'hA7);
        wr(8'hC5, 8'h43);
        rd(8'hC5, 8'hC3);
        chk("meter", {7'h00, metering_shutdown_q}, 8'h01);
        wr(8'hC1, 8'hA7);
        wr(8'hFB, 8'h00);
        wr(8'hC5, 8'h05);
        rd(8'hC5, 8'hC3);
        for (i = 0; i < 8; i++) begin
            wr(8'hC1, 8'hA7);
            wr(8'hC5, i[7:0]);
            chk("divider", {5'h00, core_clock_divider_q}, i[7:0]);
        end
        // Main supply loss, deep sleep, then restore
        wr(8'hEC, 8'h82);
        vdd_ok = 1'b0;
        tick(4);
        chk("rail", {6'h00, internal_supply_rail_q, battery_run_mode_q}, 8'h01);
        chk("irq", {7'h00, supply_irq_q}, 8'h01);
        rd(8'hF8, 8'h02);
        wr(8'hC1, 8'hA7);
        wr(8'hC5, 8'h10);
        tick(1);
        chk("sleep", {7'h00, deep_sleep_mode_q}, 8'h01);
        vdd_ok = 1'b1;
        tick(4);
        chk("rail", {6'h00, internal_supply_rail_q, full_power_mode_q}, 8'h03);
        rd(8'hF8, 8'h82);
        wr(8'hF8, 8'h00);
        tick(2);
        rd(8'hF8, 8'h00);
        chk("irq", {7'h00, supply_irq_q}, 8'h00);
        // External control pin, supervisory level, disabled level switching
        battery_control_en = 1'b1;
        battery_control_input = 1'b0;
        tick(4);
        chk("rail", {7'h00, internal_supply_rail_q}, 8'h00);
        battery_control_input = 1'b1;
        switchover_cfg = 2'h1;
        vdcin_ok = 1'b0;
        tick(4);
        chk("rail", {7'h00, internal_supply_rail_q}, 8'h00);
        vdcin_ok = 1'b1;
        switchover_cfg = 2'h2;
        vdd_ok = 1'b0;
        tick(4);
        chk("rail", {7'h00, internal_supply_rail_q}, 8'h01);
        summarize();
    end
endmodule
